// ---- fis_flash_model.sv ----
/*
  Flash array model for the integrity scanner bench.
  Assumes one request pulse per word; the bench loads mem directly while idle.
*/
module fis_flash_model (
  input  wire logic               clock,       // Main clock
  input  wire logic               slow,        // Answer one cycle late
  input  fis_pkg::fis_flash_req_s flash_req,   // Word request
  output logic [15:0]             flash_rdata, // Word answer
  output logic                    flash_rvalid // Answer valid
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [0:31];
  logic [4:0]  addr_ff;
  logic        pend_ff;
  initial begin
    flash_rdata = 16'h0000;
    flash_rvalid = 1'b0;
    pend_ff = 1'b0;
    addr_ff = 5'h00;
  end
  always @(posedge clock) begin
    flash_rvalid <= 1'b0;
    // Idle data toggles so a stale word never passes for an answer
    flash_rdata <= ~flash_rdata;
    pend_ff <= 1'b0;
    if (flash_req.req && !slow) begin
      flash_rvalid <= 1'b1;
      flash_rdata <= mem[flash_req.addr[4:0]];
    end else if (flash_req.req) begin
      pend_ff <= 1'b1;
      addr_ff <= flash_req.addr[4:0];
    end else if (pend_ff) begin
      flash_rvalid <= 1'b1;
      flash_rdata <= mem[addr_ff];
    end
  end
endmodule // fis_flash_model

// ---- fis_pkg.sv ----
/*
  Package for the flash integrity scanner: register offsets, field positions,
  reset values, timing counts and shared types.
  Assumes an 8-bit register file reached over Avalon-MM with 32-bit data.
*/
package fis_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [3:0] IDX_CTRL_ENABLE   = 4'h0;
  localparam logic [3:0] IDX_MODE_SECTION  = 4'h1;
  localparam logic [3:0] IDX_PROGRESS      = 4'h2;
  localparam logic [3:0] IDX_IRQ_STATUS    = 4'h3;
  localparam logic [3:0] IDX_IRQ_MASK      = 4'h4;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTL_ENABLE_BIT  = 0;
  localparam int CTL_FAILURE_NMI_ENABLE_BIT   = 1;
  localparam int CTL_RESET_BIT   = 7;
  localparam int MODE_LSB        = 4;
  localparam int MODE_MSB        = 5;
  localparam int SEC_LSB         = 0;
  localparam int SEC_MSB         = 1;
  localparam int STS_BUSY_BIT    = 0;
  localparam int STS_PASS_BIT    = 1;
  localparam int IRQ_DONE_BIT    = 0;
  localparam int IRQ_FAIL_BIT    = 1;

  // ----------------------------------------------------------------
  // Encodings and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_PRIORITY     = 2'h0;
  localparam logic [1:0] MODE_RESET_SCAN   = 2'h1;
  localparam logic [1:0] SEC_WHOLE_FLASH   = 2'h0;
  localparam logic [1:0] SEC_BOOT_AND_APP  = 2'h1;
  localparam logic [1:0] SEC_BOOT_ONLY     = 2'h2;
  localparam logic [7:0] RST_CONFIG        = 8'h00;
  localparam logic [7:0] RST_PROGRESS      = 8'h02;
  localparam logic [15:0] CRC_SEED         = 16'hffff;
  localparam logic [15:0] CRC_POLY         = 16'h1021;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLOCK_MHZ        = 200;
  localparam int START_DELAY_CYC  = 3;
  localparam int FETCH_PERIOD_CYC = 3;

  typedef enum {FIS_IDLE, FIS_ARM, FIS_FETCH, FIS_WAIT} fis_state_e;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [3:0]  address;
    logic [31:0] writedata;
  } fis_bus_req_s;

  typedef struct packed {
    logic        req;
    logic [15:0] addr;
  } fis_flash_req_s;

endpackage : fis_pkg

// ---- fis_scanner.sv ----
/*
  Flash integrity scanner: control, mode/section config, progress/result
  status, CRC engine, failure NMI and maskable event interrupt.
  Assumes a flash array answering a word read with valid one or more cycles later,
  and section end addresses supplied as inputs (fuse-like, stable).
*/
module fis_scanner #(
  parameter int ADDR_W = 16
) (
  input  wire logic              clock,          // 200 MHz main clock
  input  wire logic              rst_n,          // Sync system reset
  input  wire logic              reset_scan,     // Check requested at reset init
  input  wire logic [1:0]        reset_section,  // Section for reset-time check
  input  wire logic              reset_failure_nmi_enable,    // Failure NMI enable at reset init, taken only with reset_scan
  input  wire logic [ADDR_W-1:0] boot_end,       // Last word of boot section
  input  wire logic [ADDR_W-1:0] app_end,        // Last word of app code section
  input  wire logic [ADDR_W-1:0] flash_end,      // Last word of flash
  input  wire logic [3:0]        avs_address,    // Register index
  input  wire logic              avs_read,       // Read strobe
  input  wire logic              avs_write,      // Write strobe
  input  wire logic [31:0]       avs_writedata,  // Write data
  input  wire logic [3:0]        avs_byteenable, // Byte enables
  output logic [31:0]            avs_readdata,   // Read data
  output logic                   avs_waitrequest,// Wait request
  output logic                   cpu_stall,      // Holds processor off flash
  output fis_pkg::fis_flash_req_s flash_req,     // Flash word request
  input  wire logic [15:0]       flash_rdata,    // Flash word
  input  wire logic              flash_rvalid,   // Flash word valid
  output logic                   nmi,            // Failure NMI, held
  output logic                   irq             // Maskable event interrupt
);

  if (ADDR_W < 2 || ADDR_W > 16) begin : g_addr_w_check
    $error("ADDR_W out of range");
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic                    enable_ff, failure_nmi_enable_ff, pass_ff, busy_ff, nmi_ff;
  logic [1:0]              mode_ff, section_ff;
  logic [1:0]              irq_sts_ff, irq_mask_ff;
  logic [1:0]              cnt_ff;
  logic [15:0]             crc_ff;
  logic [ADDR_W-1:0]       addr_ff, end_ff;
  logic                    last_ff, boot_ff, ack_ff, got_ff;
  logic [31:0]             rdata_ff;
  fis_pkg::fis_state_e     state_ff;

  logic wr, wr_ctrl, wr_cfg, start, strobe_rst, done, fail;
  logic [7:0] wb;

  assign wb         = avs_writedata[7:0];
  // Writes commit at the acknowledging edge, when waitrequest is low
  assign wr         = avs_write && avs_byteenable[0] && ack_ff;
  assign wr_ctrl    = wr && avs_address == fis_pkg::IDX_CTRL_ENABLE && !nmi_ff;
  assign wr_cfg     = wr && avs_address == fis_pkg::IDX_MODE_SECTION
                      && !busy_ff && !nmi_ff;
  assign start      = wr_ctrl && wb[fis_pkg::CTL_ENABLE_BIT];
  assign strobe_rst = wr_ctrl && wb[fis_pkg::CTL_RESET_BIT] && !(failure_nmi_enable_ff && busy_ff);
  assign done       = state_ff == fis_pkg::FIS_WAIT && flash_rvalid && last_ff;
  assign fail       = done && (crc_next(crc_ff, flash_rdata) != 16'h0000);

  function automatic logic [15:0] crc_next(input logic [15:0] c, input logic [15:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 15; i >= 0; i--) begin
      r = {r[14:0], 1'b0} ^ ((r[15] ^ d[i]) ? fis_pkg::CRC_POLY : 16'h0000);
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Bus slave: one wait cycle, then ack
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) ack_ff <= 1'b0;
    else        ack_ff <= (avs_read || avs_write) && !ack_ff;
  end
  assign avs_waitrequest = (avs_read || avs_write) && !ack_ff;

  always_ff @(posedge clock) begin
    if (!rst_n) rdata_ff <= 32'h0000_0000;
    else if (avs_read && !ack_ff) begin
      unique case (avs_address)
        fis_pkg::IDX_CTRL_ENABLE:  rdata_ff <= {30'h0, failure_nmi_enable_ff, enable_ff};
        fis_pkg::IDX_MODE_SECTION: rdata_ff <= {26'h0, mode_ff, 2'h0, section_ff};
        fis_pkg::IDX_PROGRESS:     rdata_ff <= {30'h0, pass_ff && !busy_ff, busy_ff};
        fis_pkg::IDX_IRQ_STATUS:   rdata_ff <= {30'h0, irq_sts_ff};
        fis_pkg::IDX_IRQ_MASK:     rdata_ff <= {30'h0, irq_mask_ff};
        default:                   rdata_ff <= 32'h0000_0000;
      endcase
    end
  end
  assign avs_readdata = rdata_ff;

  // ----------------------------------------------------------------
  // Control and config
  // ----------------------------------------------------------------
  // Reset-time check is captured at reset release, not by the reset itself
  logic boot_pend_ff;
  always_ff @(posedge clock) begin
    if (!rst_n) boot_pend_ff <= 1'b1;
    else        boot_pend_ff <= 1'b0;
  end
  assign boot_ff = boot_pend_ff && reset_scan;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      enable_ff  <= 1'b0;
      mode_ff    <= fis_pkg::RST_CONFIG[fis_pkg::MODE_MSB:fis_pkg::MODE_LSB];
      section_ff <= fis_pkg::RST_CONFIG[fis_pkg::SEC_MSB:fis_pkg::SEC_LSB];
    end else if (boot_ff) begin
      enable_ff  <= 1'b1;
      mode_ff    <= fis_pkg::MODE_RESET_SCAN;
      section_ff <= reset_section;
    end else if (strobe_rst) begin
      enable_ff  <= 1'b0;
      mode_ff    <= 2'h0;
      section_ff <= 2'h0;
    end else begin
      if (wr_ctrl && !busy_ff) enable_ff <= wb[fis_pkg::CTL_ENABLE_BIT];
      else if (start)          enable_ff <= 1'b1;
      if (wr_cfg) begin
        mode_ff    <= wb[fis_pkg::MODE_MSB:fis_pkg::MODE_LSB];
        section_ff <= wb[fis_pkg::SEC_MSB:fis_pkg::SEC_LSB];
      end
    end
  end

  // Failure NMI enable only clears on system reset
  always_ff @(posedge clock) begin
    if (!rst_n)                                       failure_nmi_enable_ff <= 1'b0;
    else if (boot_ff && reset_failure_nmi_enable)                  failure_nmi_enable_ff <= 1'b1;
    else if (wr_ctrl && !busy_ff && wb[fis_pkg::CTL_FAILURE_NMI_ENABLE_BIT]) failure_nmi_enable_ff <= 1'b1;
  end

  always_ff @(posedge clock) begin
    if (!rst_n)                   nmi_ff <= 1'b0;
    else if (fail && failure_nmi_enable_ff)    nmi_ff <= 1'b1;
  end
  assign nmi = nmi_ff;

  // ----------------------------------------------------------------
  // Scan sequencer
  // ----------------------------------------------------------------
  logic go;
  assign go = (start || boot_ff) && !strobe_rst;
  // Reserved mode codes still run as a priority check; only 0x0 and 0x1 are defined

  always_ff @(posedge clock) begin
    if (!rst_n || strobe_rst) begin
      state_ff <= fis_pkg::FIS_IDLE;
      cnt_ff   <= 2'h0;
      addr_ff  <= '0;
      crc_ff   <= fis_pkg::CRC_SEED;
      got_ff   <= 1'b0;
    end else if (go) begin
      state_ff <= fis_pkg::FIS_ARM;
      cnt_ff   <= 2'(fis_pkg::START_DELAY_CYC - 1);
      addr_ff  <= '0;
      crc_ff   <= fis_pkg::CRC_SEED;
      got_ff   <= 1'b0;
    end else begin
      unique case (state_ff)
        fis_pkg::FIS_IDLE: ;
        fis_pkg::FIS_ARM: begin
          if (cnt_ff == 2'h0) state_ff <= fis_pkg::FIS_FETCH;
          else                cnt_ff   <= cnt_ff - 2'h1;
        end
        fis_pkg::FIS_FETCH: begin
          state_ff <= fis_pkg::FIS_WAIT;
          cnt_ff   <= 2'(fis_pkg::FETCH_PERIOD_CYC - 2);
          got_ff   <= 1'b0;
        end
        fis_pkg::FIS_WAIT: begin
          if (cnt_ff != 2'h0) cnt_ff <= cnt_ff - 2'h1;
          if (flash_rvalid) begin
            crc_ff <= crc_next(crc_ff, flash_rdata);
            got_ff <= 1'b1;
          end
          // Early answers wait out the count so fetches never come faster
          if (flash_rvalid && last_ff) state_ff <= fis_pkg::FIS_IDLE;
          else if ((flash_rvalid || got_ff) && cnt_ff == 2'h0) begin
            addr_ff  <= addr_ff + ADDR_W'(1);
            state_ff <= fis_pkg::FIS_FETCH;
          end
        end
      endcase
    end
  end

  always_comb begin
    unique case (section_ff)
      fis_pkg::SEC_BOOT_AND_APP: end_ff = app_end;
      fis_pkg::SEC_BOOT_ONLY:    end_ff = boot_end;
      default:                   end_ff = flash_end;
    endcase
  end
  assign last_ff = addr_ff == end_ff;

  assign flash_req.req  = state_ff == fis_pkg::FIS_FETCH;
  assign flash_req.addr = 16'(addr_ff);
  assign cpu_stall      = state_ff == fis_pkg::FIS_FETCH || state_ff == fis_pkg::FIS_WAIT;

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      busy_ff <= fis_pkg::RST_PROGRESS[fis_pkg::STS_BUSY_BIT];
      pass_ff <= fis_pkg::RST_PROGRESS[fis_pkg::STS_PASS_BIT];
    end else if (strobe_rst) begin
      busy_ff <= 1'b0;
      pass_ff <= 1'b0;
    end else if (go) begin
      busy_ff <= 1'b1;
      pass_ff <= 1'b0;
    end else if (done) begin
      busy_ff <= 1'b0;
      pass_ff <= !fail;
    end
  end

  // ----------------------------------------------------------------
  // Event interrupt: sticky, write one to clear, set wins
  // ----------------------------------------------------------------
  logic [1:0] ev;
  assign ev = {fail, done};
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      irq_sts_ff  <= 2'h0;
      irq_mask_ff <= 2'h0;
    end else begin
      irq_sts_ff <= (irq_sts_ff & ~((wr && avs_address == fis_pkg::IDX_IRQ_STATUS)
                    ? wb[1:0] : 2'h0)) | ev;
      if (wr && avs_address == fis_pkg::IDX_IRQ_MASK) irq_mask_ff <= wb[1:0];
    end
  end
  assign irq = |(irq_sts_ff & irq_mask_ff);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_start;
    go;
  endsequence
  sequence s_arm;
    (state_ff == fis_pkg::FIS_ARM) [*3];
  endsequence

  property p_cfg_locked;
    @(posedge clock) disable iff (!rst_n)
    (busy_ff || nmi_ff) && !strobe_rst && !boot_ff |=> $stable(mode_ff) && $stable(section_ff);
  endproperty
  a_cfg_locked: assert property (p_cfg_locked) else $error("config changed while locked");

  property p_start_delay;
    @(posedge clock) disable iff (!rst_n || strobe_rst)
    s_start |=> s_arm ##1 flash_req.req;
  endproperty
  a_start_delay: assert property (p_start_delay) else $error("fetch not three cycles after enable");

  property p_fetch_rate;
    @(posedge clock) disable iff (!rst_n || strobe_rst || go)
    flash_req.req |=> !flash_req.req ##1 !flash_req.req;
  endproperty
  a_fetch_rate: assert property (p_fetch_rate) else $error("fetch faster than every third cycle");

  property p_pass_zero_busy;
    @(posedge clock) disable iff (!rst_n)
    avs_read && !ack_ff && avs_address == fis_pkg::IDX_PROGRESS && busy_ff
      |=> !avs_readdata[fis_pkg::STS_PASS_BIT];
  endproperty
  a_pass_zero_busy: assert property (p_pass_zero_busy) else $error("pass visible while busy");

  property p_enable_clears_pass;
    @(posedge clock) disable iff (!rst_n)
    go |=> busy_ff && !pass_ff;
  endproperty
  a_enable_clears_pass: assert property (p_enable_clears_pass) else $error("enable did not clear pass");

  property p_nmi_held;
    @(posedge clock) disable iff (!rst_n)
    nmi_ff |=> nmi_ff;
  endproperty
  a_nmi_held: assert property (p_nmi_held) else $error("nmi dropped before reset");

  property p_fail_nmi;
    @(posedge clock) disable iff (!rst_n)
    fail && failure_nmi_enable_ff |=> nmi_ff && !pass_ff;
  endproperty
  a_fail_nmi: assert property (p_fail_nmi) else $error("failure without nmi");

  property p_done_result;
    @(posedge clock) disable iff (!rst_n || strobe_rst || go)
    done |=> !busy_ff && (pass_ff == $past(!fail));
  endproperty
  a_done_result: assert property (p_done_result) else $error("wrong result at end");

endmodule // fis_scanner

// ---- fis_tb.sv ----
/*
  Self-checking bench for the flash integrity scanner.
  Assumes a 32-word flash model with boot, app and flash ends at 7, 15, 31.
*/
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0, rst_n = 1'b0, reset_scan = 1'b0, reset_failure_nmi_enable = 1'b0, slow = 1'b0;
  logic [1:0] reset_section = 2'h0;
  logic [3:0] avs_address = 4'h0, avs_byteenable = 4'h1;
  logic avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest, cpu_stall, flash_rvalid, nmi, irq;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rq;
  logic [15:0] flash_rdata, last_addr;
  fis_pkg::fis_flash_req_s flash_req;
  int seed = 57713, num_errors = 0, n_checks = 0, cyc = 0, t_ack = 0, last_req = 0;
  bit first_q = 1'b0;

  fis_scanner #(.ADDR_W(16)) DUT (.clock(clock), .rst_n(rst_n), .reset_scan(reset_scan),
    .reset_section(reset_section), .reset_failure_nmi_enable(reset_failure_nmi_enable), .boot_end(16'h0007),
    .app_end(16'h000f), .flash_end(16'h001f), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .cpu_stall(cpu_stall),
    .flash_req(flash_req), .flash_rdata(flash_rdata), .flash_rvalid(flash_rvalid), .nmi(nmi), .irq(irq));
  fis_flash_model u_flash (.clock(clock), .slow(slow), .flash_req(flash_req),
    .flash_rdata(flash_rdata), .flash_rvalid(flash_rvalid));

  always #2.5 clock = ~clock;
  always @(posedge clock) cyc <= cyc + 1;

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // ----------------------------------------------------------------
  // Flash fetch monitor
  // ----------------------------------------------------------------
  always @(negedge clock) if (flash_req.req === 1'b1) begin
    chk("cpu_stall", 32'h1, {31'h0, cpu_stall});
    if (first_q) chk("start delay", 32'(t_ack + fis_pkg::START_DELAY_CYC), 32'(cyc));
    else if (!slow) chk("fetch spacing", 32'(fis_pkg::FETCH_PERIOD_CYC), 32'(cyc - last_req));
    first_q = 1'b0;
    last_req = cyc;
    last_addr = flash_req.addr;
  end

  // Holds the request until waitrequest is sampled low at a rising edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge clock);
    while (avs_waitrequest !== 1'b0 && n < 100) begin
      @(posedge clock);
      n++;
    end
    if (n == 100) chk("waitrequest", 32'h0, 32'h1);
    rq = avs_readdata;
    if (wr && a == fis_pkg::IDX_CTRL_ENABLE) t_ack = cyc + 1;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [15:0] w);
    for (int i = 15; i >= 0; i--) begin
      c = {c[14:0], 1'b0} ^ ((c[15] ^ w[i]) ? fis_pkg::CRC_POLY : 16'h0000);
    end
    return c;
  endfunction

  function automatic logic [31:0] end_of(input logic [1:0] s);
    return (s == fis_pkg::SEC_WHOLE_FLASH) ? 32'h1f : (s == fis_pkg::SEC_BOOT_AND_APP) ? 32'h0f : 32'h07;
  endfunction

  // Checksum words stored last in each section, inner sections first
  task automatic fill(input int bad);
    logic [15:0] c;
    for (int i = 0; i < 32; i++) u_flash.mem[i] = 16'($random(seed));
    for (int e = 7; e < 32; e++) if (e == 7 || e == 15 || e == 31) begin
      c = fis_pkg::CRC_SEED;
      for (int j = 0; j < e; j++) c = crc_upd(c, u_flash.mem[j]);
      u_flash.mem[e] = c;
    end
    if (bad >= 0) u_flash.mem[bad] = u_flash.mem[bad] ^ 16'h0001;
  endtask

  task automatic wait_idle(input logic [7:0] cfg);
    int n;
    n = 0;
    bus(1'b0, fis_pkg::IDX_PROGRESS, 8'h00);
    while (rq[fis_pkg::STS_BUSY_BIT] === 1'b1 && n < 200) begin
      chk("pass while busy", 32'h0, {31'h0, rq[fis_pkg::STS_PASS_BIT]});
      if (n == 0) bus(1'b1, fis_pkg::IDX_MODE_SECTION, 8'h32);
      n++;
      bus(1'b0, fis_pkg::IDX_PROGRESS, 8'h00);
    end
    chk("busy end", 32'h0, {31'h0, rq[fis_pkg::STS_BUSY_BIT]});
    bus(1'b0, fis_pkg::IDX_MODE_SECTION, 8'h00);
    chk("config kept", {24'h0, cfg}, rq);
  endtask

  task automatic run_scan(input logic [1:0] sec, input logic ok);
    bus(1'b1, fis_pkg::IDX_MODE_SECTION, {2'h0, fis_pkg::MODE_PRIORITY, 2'h0, sec});
    bus(1'b0, fis_pkg::IDX_MODE_SECTION, 8'h00);
    chk("config", {30'h0, sec}, rq);
    first_q = 1'b1;
    bus(1'b1, fis_pkg::IDX_CTRL_ENABLE, 8'h01);
    wait_idle({6'h0, sec});
    bus(1'b0, fis_pkg::IDX_PROGRESS, 8'h00);
    chk("status", ok ? 32'h2 : 32'h0, rq);
    chk("last word", end_of(sec), {16'h0, last_addr});
    $display("test scan section %0d slow %0d done", sec, slow);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    #200000;
    num_errors++;
    finish_test();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    bus(1'b0, fis_pkg::IDX_MODE_SECTION, 8'h00);
    chk("config reset", 32'h0, rq);
    bus(1'b1, fis_pkg::IDX_PROGRESS, 8'hff);
    bus(1'b0, fis_pkg::IDX_PROGRESS, 8'h00);
    chk("status reset", 32'h2, rq);
    bus(1'b0, 4'hf, 8'h00);
    chk("unmapped", 32'h0, rq);
    $display("test registers done");
    fill(-1);
    for (int k = 0; k < 6; k++) begin
      @(posedge clock);
      slow <= (k > 2) ? 1'($random(seed)) : 1'b0;
      run_scan((k < 3) ? 2'(k) : 2'(($random(seed) & 32'h7fff) % 3), 1'b1);
    end
    bus(1'b0, fis_pkg::IDX_IRQ_STATUS, 8'h00);
    chk("done event", 32'h1, {31'h0, rq[fis_pkg::IRQ_DONE_BIT]});
    chk("irq masked", 32'h0, {31'h0, irq});
    bus(1'b1, fis_pkg::IDX_IRQ_MASK, 8'h03);
    @(negedge clock);
    chk("irq unmasked", 32'h1, {31'h0, irq});
    bus(1'b1, fis_pkg::IDX_IRQ_STATUS, 8'h01);
    @(negedge clock);
    chk("irq cleared", 32'h0, {31'h0, irq});
    fill(3);
    bus(1'b1, fis_pkg::IDX_CTRL_ENABLE, 8'h02);
    run_scan(fis_pkg::SEC_BOOT_ONLY, 1'b0);
    @(negedge clock);
    chk("nmi raised", 32'h3, {30'h0, irq, nmi});
    bus(1'b1, fis_pkg::IDX_MODE_SECTION, 8'h01);
    bus(1'b0, fis_pkg::IDX_MODE_SECTION, 8'h00);
    chk("config after nmi", 32'h2, rq);
    fill(-1);
    @(posedge clock);
    slow <= 1'b1;
    rst_n <= 1'b0;
    reset_scan <= 1'b1;
    reset_section <= fis_pkg::SEC_BOOT_AND_APP;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    reset_scan <= 1'b0;
    bus(1'b0, fis_pkg::IDX_MODE_SECTION, 8'h00);
    chk("reset mode", 32'h1, {31'h0, |rq[5:4]});
    chk("reset section", 32'h1, {30'h0, rq[1:0]});
    wait_idle({2'h0, fis_pkg::MODE_RESET_SCAN, 2'h0, fis_pkg::SEC_BOOT_AND_APP});
    bus(1'b0, fis_pkg::IDX_PROGRESS, 8'h00);
    chk("reset scan status", 32'h2, {rq[31:1], nmi});
    bus(1'b1, fis_pkg::IDX_MODE_SECTION, 8'h01);
    bus(1'b0, fis_pkg::IDX_MODE_SECTION, 8'h00);
    chk("mode rewritten", 32'h1, rq);
    bus(1'b1, fis_pkg::IDX_CTRL_ENABLE, 8'h80);
    bus(1'b0, fis_pkg::IDX_CTRL_ENABLE, 8'h00);
    chk("strobe ctrl", 32'h0, rq);
    bus(1'b0, fis_pkg::IDX_MODE_SECTION, 8'h00);
    chk("strobe config", 32'h0, rq);
    bus(1'b0, fis_pkg::IDX_PROGRESS, 8'h00);
    chk("strobe status", 32'h0, rq);
    $display("test reset-time scan done");
    finish_test();
  end
endmodule // tb
